// ---- verilog/stepper_cfg_regs.svh ----
`ifndef STEPPER_CFG_REGS_SVH
`define STEPPER_CFG_REGS_SVH

// Register offsets
`define ADDR_FAULT_PROTECT 6'h06
`define ADDR_BLANK_STALL 6'h07
`define ADDR_THR_LOW 6'h08

// Reset values
`define FAULT_PROTECT_RESET 8'h38
`define BLANK_STALL_RESET 8'h49
`define THR_LOW_RESET 8'h03
`define RD_UNMAPPED 8'h00

// Fault and protection control fields
`define FP_CLEAR 7
`define FP_LOCK_HI 6
`define FP_LOCK_LO 4
`define FP_DEGLITCH 3
`define FP_OC_RETRY 2
`define FP_OT_RETRY 1
`define FP_TW_REPORT 0
`define LOCK_KEY_CLOSE 3'h6
`define LOCK_KEY_OPEN 3'h3

// Blanking, stall and step control fields
`define BS_BLANK_HI 7
`define BS_BLANK_LO 6
`define BS_LEARN 5
`define BS_STALL_EN 4
`define BS_STALL_REP 3
`define BS_BYPASS 2
`define BS_TOL_HI 1
`define BS_TOL_LO 0

// Serial frame: bit 15 zero, bit 14 read, 13:8 address, 7:0 data
`define FRAME_BITS 5'h10
`define HEADER_BITS 5'h08

// Timing, in ns, and cycles at the system clock
`define CLK_PERIOD_NS 100
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEGLITCH_LONG_NS 2200
`define DEGLITCH_SHORT_NS 1200
`define BLANK_0_NS 1000
`define BLANK_1_NS 1500
`define BLANK_2_NS 2000
`define BLANK_3_NS 2500
`define RETRY_TIME_NS 4000000

// Step tolerance as a right shift of the last period (1/128, 1/64, 1/32, 1/16)
`define TOL_SHIFT_0 7
`define TOL_SHIFT_1 6
`define TOL_SHIFT_2 5
`define TOL_SHIFT_3 4

`endif

// ---- verilog/stepper_cfg_pkg.sv ----
package stepper_cfg_pkg;
  typedef logic [7:0] reg_byte_type;
  typedef logic [5:0] reg_addr_type;
  typedef logic [11:0] thr_type;
  typedef enum logic {LOCK_OPEN, LOCK_CLOSED} lock_state_type;
  typedef enum logic [1:0] {LINK_IDLE, LINK_SHIFT, LINK_LOAD} link_state_type;
endpackage

// ---- verilog/reg_access_if.sv ----
`timescale 1ns/1ps
interface reg_access_if;
  import stepper_cfg_pkg::*;
  logic wr_stb;
  reg_addr_type addr;
  reg_byte_type wdata;
  reg_byte_type rdata;
  modport link (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ---- verilog/reg_serial_link.sv ----
`timescale 1ns/1ps
`include "stepper_cfg_regs.svh"
module reg_serial_link (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic scs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Register side
  reg_access_if.link bus
);
  import stepper_cfg_pkg::*;
  localparam int NSYNC = 3;
  logic [NSYNC-1:0] raw;
  logic s1_q [NSYNC];
  logic s2_q [NSYNC];
  logic sclk_prev_q;
  logic [15:0] rx_q;
  reg_byte_type tx_q;
  logic [4:0] bits_q;
  logic sdo_q;
  logic wr_q;
  reg_addr_type addr_q;
  reg_byte_type wdata_q;
  link_state_type state_q;
  wire sclk_rise;
  wire sclk_fall;
  wire active;
  wire frame_end;

  assign raw = {sdi_i, scs_n_i, sclk_i};
  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
      end else if (ce_i) begin
        s1_q[g] <= raw[g];
        s2_q[g] <= s1_q[g];
      end
    end
  end

  assign active = !s2_q[1];
  assign sclk_rise = s2_q[0] && !sclk_prev_q;
  assign sclk_fall = !s2_q[0] && sclk_prev_q;
  // Write only for a whole frame with a clean leading bit
  assign frame_end = !active && state_q != LINK_IDLE && bits_q == `FRAME_BITS
                     && !rx_q[15] && !rx_q[14];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= LINK_IDLE;
      sclk_prev_q <= 1'b0;
      rx_q <= '0;
      tx_q <= '0;
      bits_q <= '0;
      sdo_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else if (ce_i) begin
      sclk_prev_q <= s2_q[0];
      wr_q <= frame_end;
      if (frame_end) begin
        wdata_q <= rx_q[7:0];
      end
      unique case (state_q)
        LINK_IDLE: begin
          bits_q <= '0;
          sdo_q <= 1'b0;
          if (active) begin
            state_q <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (!active) begin
            state_q <= LINK_IDLE;
          end else if (sclk_fall) begin
            rx_q <= {rx_q[14:0], s2_q[2]};
            bits_q <= bits_q + 5'h01;
            if (bits_q == `HEADER_BITS - 5'h01) begin
              addr_q <= {rx_q[4:0], s2_q[2]};
              state_q <= LINK_LOAD;
            end
          end else if (sclk_rise && bits_q >= `HEADER_BITS) begin
            sdo_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        LINK_LOAD: begin
          // Register value captured mid-frame so it shifts out as data
          tx_q <= bus.rdata;
          state_q <= active ? LINK_SHIFT : LINK_IDLE;
        end
      endcase
    end
  end

  assign sdo_o = sdo_q;
  assign sdo_oe_o = active;
  assign bus.wr_stb = wr_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
endmodule // reg_serial_link

// ---- verilog/stepper_protect_stall_config_regs.sv ----
`timescale 1ns/1ps
`include "stepper_cfg_regs.svh"
// Functional notes
// - Clear strobe clears latched faults, self-clears
// - Key 110b locks; only lock, clear writable
// - Unlocked: other lock values change nothing
// - Key 011b unlocks all registers
// - Locked: other lock values change nothing
// - Deglitch select: 2.2 us set, 1.2 us clear
// - Overcurrent: zero latches, one auto-retries
// - Overtemperature: zero latches, one auto-retries
// - Warning report bit gates warnings onto fault
// - Blanking field picks 1 to 2.5 us
// - Learn bit starts learning, hardware clears it
// - Stall detect enable turns detection on
// - Stall report bit gates stall onto fault
// - Bypass bit passes step input unfiltered
// - Tolerance field picks 1/128, 1/64, 1/32, 1/16 of the period
// - Threshold low byte, resets to three
// - High nibble from separate register combined
module stepper_protect_stall_config_regs #(
  parameter int RETRY_CYCLES = `CYC_UP(`RETRY_TIME_NS),
  parameter int PERIOD_W = 16
) (
  // Clock, reset and enable
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Serial register port
  input wire logic sclk_i,
  input wire logic scs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Protection detectors, asynchronous
  input wire logic overcurrent_i,
  input wire logic overtemp_i,
  input wire logic temp_warn_i,
  input wire logic stall_i,
  // Step pin, asynchronous
  input wire logic step_i,
  // Same-clock inputs
  input wire logic pwm_on_i,
  input wire logic learn_done_i,
  input wire logic [3:0] stall_threshold_high_i,
  // Fault reporting
  output logic fault_out_n_o,
  output logic oc_fault_o,
  output logic ot_fault_o,
  output logic stall_fault_o,
  // Configuration and timing
  output logic blank_o,
  output logic step_o,
  output logic stall_learn_start_o,
  output logic stall_detect_enable_o,
  output stepper_cfg_pkg::thr_type stall_threshold_o,
  output logic locked_o
);
  import stepper_cfg_pkg::*;

  localparam int DEG_LONG = `CYC_UP(`DEGLITCH_LONG_NS);
  localparam int DEG_SHORT = `CYC_UP(`DEGLITCH_SHORT_NS);
  localparam int DEG_W = $clog2(DEG_LONG + 1);
  localparam int BLANK_W = $clog2(`CYC_UP(`BLANK_3_NS) + 1);
  localparam int RETRY_W = $clog2(RETRY_CYCLES + 1);
  localparam int NPIN = 5;
  localparam reg_byte_type FP_RST = `FAULT_PROTECT_RESET;
  localparam reg_byte_type BS_RST = `BLANK_STALL_RESET;
  localparam reg_byte_type THR_RST = `THR_LOW_RESET;

  function automatic logic addr_hit(input reg_addr_type a,
                                    input reg_addr_type r);
    return a == r;
  endfunction

  function automatic logic [BLANK_W-1:0] blank_cycles(input logic [1:0] s);
    unique case (s)
      2'h0: return BLANK_W'(`CYC_UP(`BLANK_0_NS));
      2'h1: return BLANK_W'(`CYC_UP(`BLANK_1_NS));
      2'h2: return BLANK_W'(`CYC_UP(`BLANK_2_NS));
      2'h3: return BLANK_W'(`CYC_UP(`BLANK_3_NS));
    endcase
  endfunction

  function automatic logic [PERIOD_W-1:0] tol_margin(
      input logic [PERIOD_W-1:0] p, input logic [1:0] s);
    unique case (s)
      2'h0: return p >> `TOL_SHIFT_0;
      2'h1: return p >> `TOL_SHIFT_1;
      2'h2: return p >> `TOL_SHIFT_2;
      2'h3: return p >> `TOL_SHIFT_3;
    endcase
  endfunction

  // Reset release synchroniser
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Pin synchronisers
  logic [NPIN-1:0] pin_raw;
  logic pin_s1_q [NPIN];
  logic pin_s2_q [NPIN];
  assign pin_raw = {step_i, stall_i, temp_warn_i, overtemp_i, overcurrent_i};
  for (genvar g = 0; g < NPIN; g++) begin : g_pin_sync
    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        pin_s1_q[g] <= 1'b0;
        pin_s2_q[g] <= 1'b0;
      end else if (ce_i) begin
        pin_s1_q[g] <= pin_raw[g];
        pin_s2_q[g] <= pin_s1_q[g];
      end
    end
  end
  wire oc_s = pin_s2_q[0];
  wire ot_s = pin_s2_q[1];
  wire tw_s = pin_s2_q[2];
  wire stall_s = pin_s2_q[3];
  wire step_s = pin_s2_q[4];

  // Serial register access
  reg_access_if bus ();
  reg_serial_link u_link (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .sclk_i(sclk_i),
    .scs_n_i(scs_n_i),
    .sdi_i(sdi_i),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .bus(bus.link)
  );

  // Register state
  lock_state_type lock_q;
  lock_state_type lock_d;
  logic [3:0] fp_q;
  reg_byte_type bs_q;
  reg_byte_type bs_d;
  reg_byte_type thr_q;

  wire wr_fp = bus.wr_stb && addr_hit(bus.addr, `ADDR_FAULT_PROTECT);
  wire wr_bs = bus.wr_stb && addr_hit(bus.addr, `ADDR_BLANK_STALL);
  wire wr_thr = bus.wr_stb && addr_hit(bus.addr, `ADDR_THR_LOW);
  wire open = lock_q == LOCK_OPEN;
  wire [2:0] lock_field = bus.wdata[`FP_LOCK_HI:`FP_LOCK_LO];
  // Clear is honoured even while locked
  wire fault_clear_strobe = wr_fp && bus.wdata[`FP_CLEAR];
  wire learn_set = wr_bs && open && bus.wdata[`BS_LEARN];

  always_comb begin
    lock_d = lock_q;
    unique case (lock_q)
      LOCK_OPEN: begin
        if (wr_fp && lock_field == `LOCK_KEY_CLOSE) begin
          lock_d = LOCK_CLOSED;
        end
      end
      LOCK_CLOSED: begin
        if (wr_fp && lock_field == `LOCK_KEY_OPEN) begin
          lock_d = LOCK_OPEN;
        end
      end
    endcase
  end

  // Learn bit: a fresh start wins over a finishing learn in the same cycle
  always_comb begin
    bs_d = bs_q;
    if (wr_bs && open) begin
      bs_d = bus.wdata;
    end
    bs_d[`BS_LEARN] = learn_set || (bs_q[`BS_LEARN] && !learn_done_i);
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= LOCK_OPEN;
      fp_q <= FP_RST[3:0];
      bs_q <= BS_RST;
      thr_q <= THR_RST;
    end else if (ce_i) begin
      lock_q <= lock_d;
      bs_q <= bs_d;
      if (wr_fp && open) begin
        fp_q <= bus.wdata[3:0];
      end
      if (wr_thr && open) begin
        thr_q <= bus.wdata;
      end
    end
  end

  // Readback: lock field shows the key of the current state
  wire [2:0] lock_rd = open ? `LOCK_KEY_OPEN : `LOCK_KEY_CLOSE;
  wire [7:0] fp_rd = {1'b0, lock_rd, fp_q};
  assign bus.rdata = addr_hit(bus.addr, `ADDR_FAULT_PROTECT) ? fp_rd :
                     addr_hit(bus.addr, `ADDR_BLANK_STALL) ? bs_q :
                     addr_hit(bus.addr, `ADDR_THR_LOW) ? thr_q :
                     `RD_UNMAPPED;

  // Overcurrent deglitch: the condition must persist the selected time
  logic [DEG_W-1:0] deg_cnt_q;
  wire [DEG_W-1:0] deg_limit = fp_q[`FP_DEGLITCH] ? DEG_W'(DEG_LONG) :
                               DEG_W'(DEG_SHORT);
  wire oc_event = oc_s && deg_cnt_q == deg_limit;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      deg_cnt_q <= '0;
    end else if (ce_i) begin
      if (!oc_s) begin
        deg_cnt_q <= '0;
      end else if (!oc_event) begin
        deg_cnt_q <= deg_cnt_q + 1'b1;
      end
    end
  end

  // Fault 0 overcurrent, fault 1 overtemperature
  wire [1:0] flt_event = {ot_s, oc_event};
  wire [1:0] flt_retry = {fp_q[`FP_OT_RETRY], fp_q[`FP_OC_RETRY]};
  logic [1:0] flt_q;
  logic [RETRY_W-1:0] retry_q [2];
  for (genvar f = 0; f < 2; f++) begin : g_fault
    // Retry mode holds the fault a retry time past the condition
    wire retry_done = retry_q[f] == RETRY_W'(RETRY_CYCLES - 1);
    wire flt_next = flt_event[f] || (flt_q[f] && (flt_retry[f] ?
                    !retry_done : !fault_clear_strobe));
    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        flt_q[f] <= 1'b0;
        retry_q[f] <= '0;
      end else if (ce_i) begin
        flt_q[f] <= flt_next;
        retry_q[f] <= (flt_event[f] || !flt_q[f]) ? '0 :
                      retry_q[f] + 1'b1;
      end
    end
  end

  // Stall flag latches until cleared; the event wins over the clear
  logic stall_q;
  wire stall_en = bs_q[`BS_STALL_EN];
  wire stall_set = stall_s && stall_en;
  wire warn_rep = tw_s && fp_q[`FP_TW_REPORT];
  wire stall_rep = stall_q && bs_q[`BS_STALL_REP];
  logic fault_n_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      stall_q <= 1'b0;
      fault_n_q <= 1'b1;
    end else if (ce_i) begin
      stall_q <= stall_set || (stall_q && !fault_clear_strobe);
      fault_n_q <= !(|flt_q || warn_rep || stall_rep);
    end
  end

  // Sense blanking window started by each PWM on-time
  logic [BLANK_W-1:0] blank_cnt_q;
  logic blank_q;
  wire [1:0] blank_sel = bs_q[`BS_BLANK_HI:`BS_BLANK_LO];
  wire [BLANK_W-1:0] blank_cnt_d = pwm_on_i ? blank_cycles(blank_sel) :
                       (blank_cnt_q != '0) ? blank_cnt_q - 1'b1 :
                       blank_cnt_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      blank_cnt_q <= '0;
      blank_q <= 1'b0;
    end else if (ce_i) begin
      blank_cnt_q <= blank_cnt_d;
      blank_q <= blank_cnt_d != '0;
    end
  end

  // Step filter: an edge sooner than the last period less the tolerance
  // is taken as a glitch; slower steps are always accepted
  logic step_prev_q;
  logic step_q;
  logic have_last_q;
  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W-1:0] last_q;
  wire step_edge = step_s && !step_prev_q;
  wire [1:0] tol_sel = bs_q[`BS_TOL_HI:`BS_TOL_LO];
  wire [PERIOD_W-1:0] min_period = last_q -
                                   tol_margin(last_q, tol_sel);
  wire step_ok = bs_q[`BS_BYPASS] || !have_last_q ||
                 period_q >= min_period;
  wire period_full = &period_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      step_prev_q <= 1'b0;
      step_q <= 1'b0;
      have_last_q <= 1'b0;
      period_q <= '0;
      last_q <= '0;
    end else if (ce_i) begin
      step_prev_q <= step_s;
      step_q <= step_edge && step_ok;
      if (step_edge && step_ok) begin
        last_q <= period_q;
        period_q <= '0;
        have_last_q <= 1'b1;
      end else if (period_full) begin
        have_last_q <= 1'b0;
      end else begin
        period_q <= period_q + 1'b1;
      end
    end
  end

  // Outputs
  assign fault_out_n_o = fault_n_q;
  assign oc_fault_o = flt_q[0];
  assign ot_fault_o = flt_q[1];
  assign stall_fault_o = stall_q;
  assign blank_o = blank_q;
  assign step_o = step_q;
  assign stall_learn_start_o = bs_q[`BS_LEARN];
  assign stall_detect_enable_o = stall_en;
  assign stall_threshold_o = {stall_threshold_high_i, thr_q};
  assign locked_o = !open;
endmodule // stepper_protect_stall_config_regs

// ---- test/stepper_protect_stall_config_regs_properties.sv ----
`timescale 1ns/1ps
module stepper_cfg_checker #(
  parameter int RETRY_CYCLES = 20
) (
  // Clock, reset and enable
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Serial and detector inputs
  input wire logic scs_n_i,
  input wire logic sdo_oe_o,
  input wire logic overcurrent_i,
  input wire logic step_i,
  input wire logic pwm_on_i,
  input wire logic learn_done_i,
  input wire logic [3:0] stall_threshold_high_i,
  // Outputs watched
  input wire logic fault_out_n_o,
  input wire logic oc_fault_o,
  input wire logic ot_fault_o,
  input wire logic blank_o,
  input wire logic step_o,
  input wire logic stall_learn_start_o,
  input wire stepper_cfg_pkg::thr_type stall_threshold_o,
  input wire logic locked_o
);
  // A frozen clock enable stalls every counter, so nothing is judged then
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i || !ce_i);

  a_flag_to_fault: assert property ((oc_fault_o || ot_fault_o) |=> !fault_out_n_o)
    else $error("fault output not low after a protection flag");
  a_oc_deglitch: assert property ($rose(oc_fault_o) |-> $past(overcurrent_i, 11) && $past(overcurrent_i, 3))
    else $error("overcurrent flag set before the deglitch interval");
  a_blank_start: assert property (pwm_on_i |=> blank_o)
    else $error("blanking did not start after pwm on");
  a_blank_length: assert property ($rose(blank_o) |-> blank_o [*8] ##[3:18] !blank_o)
    else $error("blanking window length out of range");
  a_learn_ends: assert property (learn_done_i |=> !stall_learn_start_o)
    else $error("learn bit not cleared at learn done");
  a_step_single: assert property (step_o |=> !step_o)
    else $error("step pulse longer than one cycle");
  a_step_cause: assert property (step_o |-> $past(step_i, 2))
    else $error("step pulse without a step input");
  a_thr_high: assert property ($stable(stall_threshold_high_i) |-> stall_threshold_o[11:8] == stall_threshold_high_i)
    else $error("threshold upper nibble not taken from input");
  a_lock_at_end: assert property ($changed(locked_o) |-> $past(scs_n_i, 2) && $past(scs_n_i, 3))
    else $error("lock state changed inside a frame");
  a_oe_idle: assert property (scs_n_i [*6] |-> !sdo_oe_o)
    else $error("data out driven while deselected");
endmodule // stepper_cfg_checker

bind stepper_protect_stall_config_regs stepper_cfg_checker #(
  .RETRY_CYCLES(RETRY_CYCLES)
) i_chk (
  .clock_i(clock_i),
  .resetn_i(resetn_i),
  .ce_i(ce_i),
  .scs_n_i(scs_n_i),
  .sdo_oe_o(sdo_oe_o),
  .overcurrent_i(overcurrent_i),
  .step_i(step_i),
  .pwm_on_i(pwm_on_i),
  .learn_done_i(learn_done_i),
  .stall_threshold_high_i(stall_threshold_high_i),
  .fault_out_n_o(fault_out_n_o),
  .oc_fault_o(oc_fault_o),
  .ot_fault_o(ot_fault_o),
  .blank_o(blank_o),
  .step_o(step_o),
  .stall_learn_start_o(stall_learn_start_o),
  .stall_threshold_o(stall_threshold_o),
  .locked_o(locked_o)
);

// ---- test/serial_host_model.sv ----
`timescale 1ns/1ps
module serial_host_model (
  // Clock
  input wire logic clock_i,
  // Serial pins
  output logic sclk_o,
  output logic scs_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  // No pull on the data line: a released line reads inverted, so a
  // sample taken while the device is not driving shows up as a mismatch
  wire logic sdo_line;
  assign sdo_line = sdo_oe_i ? sdo_i : ~sdo_i;

  initial begin
    sclk_o = 1'b0;
    scs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // Half period of four clocks leaves room for the pin synchronisers
  task automatic xfer(input logic [15:0] frame, input int bits,
                      output logic [7:0] rdata);
    rdata = 8'h00;
    @(negedge clock_i);
    scs_n_o = 1'b0;
    repeat (4) @(negedge clock_i);
    for (int i = 15; i > 15 - bits; i--) begin
      sdi_o = frame[i];
      repeat (2) @(negedge clock_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clock_i);
      rdata = {rdata[6:0], sdo_line};
      sclk_o = 1'b0;
      repeat (2) @(negedge clock_i);
    end
    scs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (10) @(negedge clock_i);
  endtask
endmodule // serial_host_model

// ---- test/test_stepper_protect_stall_config_regs.sv ----
`timescale 1ns/1ps
module test_stepper_protect_stall_config_regs;
  import stepper_cfg_pkg::*;
  localparam int RETRY = 20;
  localparam int LIMIT = 20000;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sclk, scs_n, sdi, sdo, sdo_oe;
  logic oc = 1'b0, ot = 1'b0, warn = 1'b0, stall = 1'b0;
  logic step = 1'b0, pwm = 1'b0, done = 1'b0;
  logic fault_n, ocf, otf, stf, blank, step_out, learn, stl_en, locked;
  thr_type thr;
  reg_byte_type rdat;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  initial begin
    forever #50 clock_i = ~clock_i;
  end

  stepper_protect_stall_config_regs #(.RETRY_CYCLES(RETRY)) i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .sclk_i(sclk), .scs_n_i(scs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .overcurrent_i(oc), .overtemp_i(ot), .temp_warn_i(warn),
    .stall_i(stall), .step_i(step), .pwm_on_i(pwm),
    .learn_done_i(done), .stall_threshold_high_i(4'hA),
    .fault_out_n_o(fault_n), .oc_fault_o(ocf), .ot_fault_o(otf),
    .stall_fault_o(stf), .blank_o(blank), .step_o(step_out),
    .stall_learn_start_o(learn), .stall_detect_enable_o(stl_en),
    .stall_threshold_o(thr), .locked_o(locked));

  serial_host_model i_host (.clock_i(clock_i), .sclk_o(sclk),
    .scs_n_o(scs_n), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bit1(input string what, input logic exp, input logic got);
    chk(what, {11'h0, exp}, {11'h0, got});
  endtask

  task automatic wr(input reg_addr_type a, input reg_byte_type d);
    i_host.xfer({2'b00, a, d}, 16, rdat);
  endtask

  task automatic rd(input reg_addr_type a, input reg_byte_type e);
    i_host.xfer({2'b01, a, 8'h00}, 16, rdat);
    chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, rdat});
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clock_i);
  endtask

  initial begin
    tick(2);
    resetn_i = 1'b1;
    tick(6);
    rd(6'h06, 8'h38);
    rd(6'h07, 8'h49);
    rd(6'h08, 8'h03);
    rd(6'h10, 8'h00);
    $display("test reset values done");
    wr(6'h07, 8'h1D);
    rd(6'h07, 8'h1D);
    bit1("stall enable", 1'b1, stl_en);
    wr(6'h08, 8'hFF);
    chk("threshold", 12'hAFF, thr);
    // A 15-bit frame must not write
    i_host.xfer({2'b00, 6'h08, 8'h00}, 15, rdat);
    rd(6'h08, 8'hFF);
    $display("test access done");
    wr(6'h06, 8'h5A);
    rd(6'h06, 8'h3A);
    wr(6'h06, 8'h6A);
    bit1("locked", 1'b1, locked);
    wr(6'h08, 8'h11);
    wr(6'h07, 8'h00);
    wr(6'h06, 8'h50);
    rd(6'h08, 8'hFF);
    rd(6'h07, 8'h1D);
    rd(6'h06, 8'h6A);
    warn = 1'b1;
    tick(10);
    bit1("fault out", 1'b1, fault_n);
    oc = 1'b1;
    tick(40);
    bit1("oc flag", 1'b1, ocf);
    oc = 1'b0;
    tick(40);
    bit1("oc flag", 1'b1, ocf);
    bit1("fault out", 1'b0, fault_n);
    wr(6'h06, 8'hEA);
    bit1("oc flag", 1'b0, ocf);
    rd(6'h06, 8'h6A);
    wr(6'h06, 8'h3A);
    bit1("locked", 1'b0, locked);
    wr(6'h08, 8'h55);
    rd(6'h08, 8'h55);
    $display("test lock done");
    wr(6'h06, 8'h3B);
    bit1("fault out", 1'b0, fault_n);
    warn = 1'b0;
    tick(6);
    bit1("fault out", 1'b1, fault_n);
    ot = 1'b1;
    tick(10);
    bit1("ot flag", 1'b1, otf);
    ot = 1'b0;
    tick(RETRY + 10);
    bit1("ot flag", 1'b0, otf);
    stall = 1'b1;
    tick(6);
    bit1("stall flag", 1'b1, stf);
    bit1("fault out", 1'b0, fault_n);
    stall = 1'b0;
    wr(6'h06, 8'hBB);
    bit1("stall flag", 1'b0, stf);
    bit1("fault out", 1'b1, fault_n);
    $display("test faults done");
    wr(6'h07, 8'h3D);
    bit1("learn", 1'b1, learn);
    done = 1'b1;
    tick(1);
    done = 1'b0;
    tick(2);
    rd(6'h07, 8'h1D);
    for (int k = 0; k < 4; k++) begin
      wr(6'h07, {k[1:0], 6'h1D});
      n = 0;
      pwm = 1'b1;
      repeat (30) begin
        @(negedge clock_i);
        pwm = 1'b0;
        if (blank === 1'b1) n++;
      end
      chk("blank length", 12'(10 + 5 * k), n[11:0]);
    end
    n = 0;
    repeat (3) begin
      step = 1'b1;
      repeat (10) begin
        @(negedge clock_i);
        if (step_out === 1'b1) n++;
      end
      step = 1'b0;
      tick(10);
    end
    chk("step pulses", 12'd3, n[11:0]);
    $display("test blank learn step done");
    report_and_stop();
  end
endmodule // test_stepper_protect_stall_config_regs
